// [hw/idle_code_map.vh]
`ifndef IDLE_CODE_MAP_VH
`define IDLE_CODE_MAP_VH

// ==========================================================
// register indices (byte address is four times the index)
`define IDX_LINE_CONTROL          8'h79
`define IDX_TERMINATION_CONTROL   8'h7b
`define IDX_IDLE_ARRAY_POINTER    8'h7e
`define IDX_IDLE_CODE_VALUE       8'h7f
`define IDX_TX_IDLE_ENABLE_CH1_8  8'h80
`define IDX_TX_IDLE_ENABLE_CH9_16 8'h81
`define IDX_TX_IDLE_ENABLE_CH17_24 8'h82
`define IDX_TX_IDLE_ENABLE_CH25_32 8'h83
`define IDX_RX_IDLE_ENABLE_CH1_8  8'h84
`define IDX_RX_IDLE_ENABLE_CH9_16 8'h85
`define IDX_RX_IDLE_ENABLE_CH17_24 8'h86

// ==========================================================
// field positions
`define POS_GLOBAL_RX_FILL_FLAG   7
`define POS_GLOBAL_TX_FILL_FLAG   6
`define POS_LINE_STANDARD_SELECT  7
`define POS_TX_TERMINATION_LO     2
`define POS_RX_TERMINATION_LO     0

// ==========================================================
// reset values and channel counts
`define RST_REG8                  8'h00
`define CHANNELS_T1               6'h18
`define CHANNELS_E1               6'h20

// ==========================================================
// termination select encodings
`define TERM_OFF                  2'h0
`define TERM_75                   2'h1
`define TERM_100                  2'h2
`define TERM_120                  2'h3

`endif

// [hw/per_channel_idle_code_insert.v]
// Behaviour
// RULE_01: global flags choose single, tx, rx, all
// RULE_02: global rx flag fills every rx entry
// RULE_03: software clears global flags before reading
// RULE_04: software keeps pointer a valid channel
// RULE_05: six-bit pointer, channel one is one
// RULE_06: flags clear update only addressed channel
// RULE_07: code register holds eight-bit code
// RULE_08: tx enabled channel gets stored code
// RULE_09: rx enabled channel gets stored code
// RULE_10: enables eight per register, ascending
// RULE_11: tx termination field decodes four settings
// RULE_12: rx termination field decodes four settings
// RULE_13: line standard bit: zero T1, one E1
// RULE_14: code write commits into selected entries
// RULE_15: single update writes tx and rx
`timescale 1ns/1ps
`include "idle_code_map.vh"

// ==========================================================
// stream fifo
module stream_fifo #(
	parameter WIDTH = 14,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst_b,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr;
	reg  [AW-1:0]    rd_ptr;
	reg  [AW:0]      count;
	wire             push;
	wire             pop;

	// handshake terms
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	// pointers and fill count
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			// wrap compare also suits depths that are not powers of two
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

	// storage, no reset needed on data
	always @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule // stream_fifo

// ==========================================================
// idle code substitution top
module per_channel_idle_code_insert #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// transmit stream in
	input  wire        tx_in_valid,
	output wire        tx_in_ready,
	input  wire [7:0]  tx_in_data,
	input  wire [5:0]  tx_in_channel,
	// transmit stream out
	output wire        tx_out_valid,
	input  wire        tx_out_ready,
	output wire [7:0]  tx_out_data,
	output wire [5:0]  tx_out_channel,
	// receive stream in
	input  wire        rx_in_valid,
	output wire        rx_in_ready,
	input  wire [7:0]  rx_in_data,
	input  wire [5:0]  rx_in_channel,
	// receive stream out
	output wire        rx_out_valid,
	input  wire        rx_out_ready,
	output wire [7:0]  rx_out_data,
	output wire [5:0]  rx_out_channel,
	// line configuration
	output reg         line_standard_select,
	output reg  [2:0]  tx_termination_onehot,
	output reg  [2:0]  rx_termination_onehot
);
	reg  [7:0]  idle_array_pointer;
	reg  [7:0]  idle_code_value;
	reg  [31:0] tx_enable;
	reg  [23:0] rx_enable;
	reg  [3:0]  termination_control;
	reg  [7:0]  tx_code [0:31];
	reg  [7:0]  rx_code [0:31];
	wire [9:0]  reg_index;
	wire        addr_aligned;
	wire        mapped;
	wire        wr_en;
	wire        setup;
	wire        code_write;
	wire        global_rx_fill_flag;
	wire        global_tx_fill_flag;
	wire [5:0]  channel_pointer;
	wire        pointer_ok;
	wire [4:0]  pointer_idx;
	wire [4:0]  tx_idx;
	wire [4:0]  rx_idx;
	wire        tx_hit;
	wire        rx_hit;
	wire [31:0] rx_enable_full;
	wire [31:0] single_hit;
	integer     ei;
	wire [7:0]  tx_sub_data;
	wire [7:0]  rx_sub_data;
	reg  [7:0]  next_rdata;

	// channel number inside the count for the line standard
	// channel zero never valid, the count caps the top
	function chan_ok;
		input [5:0] ch;
		input       e1;
		begin
			chan_ok = (ch != 6'h00) && (ch <= (e1 ? `CHANNELS_E1 : `CHANNELS_T1));
		end
	endfunction

	// termination field to one-hot 75/100/120 enables
	function [2:0] term_decode;
		input [1:0] sel;
		begin
			case (sel)
				`TERM_75:  term_decode = 3'h1;
				`TERM_100: term_decode = 3'h2;
				`TERM_120: term_decode = 3'h4;
				default:   term_decode = 3'h0;
			endcase
		end
	endfunction

	// ======================================================
	// apb decode
	assign reg_index    = paddr[11:2];
	assign addr_aligned = (paddr[1:0] == 2'h0);
	assign mapped = addr_aligned && (
		(reg_index == {2'h0, `IDX_LINE_CONTROL}) ||
		(reg_index == {2'h0, `IDX_TERMINATION_CONTROL}) ||
		(reg_index == {2'h0, `IDX_IDLE_ARRAY_POINTER}) ||
		(reg_index == {2'h0, `IDX_IDLE_CODE_VALUE}) ||
		((reg_index >= {2'h0, `IDX_TX_IDLE_ENABLE_CH1_8}) &&
		 (reg_index <= {2'h0, `IDX_RX_IDLE_ENABLE_CH17_24})));
	// no wait states, access phase always one cycle
	assign pready  = 1'b1;                     // zero wait states
	assign pslverr = psel & penable & ~mapped;
	assign wr_en   = psel & penable & pwrite & mapped;
	assign setup   = psel & ~penable;

	// pointer fields
	assign global_rx_fill_flag = idle_array_pointer[`POS_GLOBAL_RX_FILL_FLAG];
	assign global_tx_fill_flag = idle_array_pointer[`POS_GLOBAL_TX_FILL_FLAG];
	// RULE_05: six-bit pointer
	assign channel_pointer = idle_array_pointer[5:0];
	assign pointer_idx     = channel_pointer[4:0] - 5'h01;
	// RULE_13: valid count follows standard
	assign pointer_ok      = chan_ok(channel_pointer, line_standard_select);
	assign code_write      = wr_en && (reg_index == {2'h0, `IDX_IDLE_CODE_VALUE});

	// ======================================================
	// configuration registers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_array_pointer   <= `RST_REG8;
			idle_code_value      <= `RST_REG8;
			tx_enable            <= 32'h00000000;
			rx_enable            <= 24'h000000;
			termination_control  <= 4'h0;
			line_standard_select <= 1'b0;
		end else if (wr_en) begin
			if (reg_index == {2'h0, `IDX_LINE_CONTROL})
				line_standard_select <= pwdata[`POS_LINE_STANDARD_SELECT];
			else if (reg_index == {2'h0, `IDX_TERMINATION_CONTROL})
				termination_control <= pwdata[3:0];
			else if (reg_index == {2'h0, `IDX_IDLE_ARRAY_POINTER})
				idle_array_pointer <= pwdata[7:0];
			// RULE_07: eight-bit code held
			else if (reg_index == {2'h0, `IDX_IDLE_CODE_VALUE})
				idle_code_value <= pwdata[7:0];
			// RULE_10: bit zero lowest channel
			else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH1_8})
				tx_enable[7:0] <= pwdata[7:0];
			else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH9_16})
				tx_enable[15:8] <= pwdata[7:0];
			else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH17_24})
				tx_enable[23:16] <= pwdata[7:0];
			else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH25_32})
				tx_enable[31:24] <= pwdata[7:0];
			else if (reg_index == {2'h0, `IDX_RX_IDLE_ENABLE_CH1_8})
				rx_enable[7:0] <= pwdata[7:0];
			else if (reg_index == {2'h0, `IDX_RX_IDLE_ENABLE_CH9_16})
				rx_enable[15:8] <= pwdata[7:0];
			else if (reg_index == {2'h0, `IDX_RX_IDLE_ENABLE_CH17_24})
				rx_enable[23:16] <= pwdata[7:0];
		end
	end

	// termination decode registers
	// one register stage behind the field
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_termination_onehot <= 3'h0;
			rx_termination_onehot <= 3'h0;
		end else begin
			// RULE_11: tx termination decode
			tx_termination_onehot <= term_decode(termination_control[`POS_TX_TERMINATION_LO +: 2]);
			// RULE_12: rx termination decode
			rx_termination_onehot <= term_decode(termination_control[`POS_RX_TERMINATION_LO +: 2]);
		end
	end

	// ======================================================
	// idle code arrays, one entry per channel
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_entry
			localparam [4:0] ENTRY = gi;
			// RULE_06: single addressed channel
			assign single_hit[gi] = pointer_ok && (pointer_idx == ENTRY);
		end
	endgenerate

	// array write; one process drives every entry so the
	// storage keeps a single driver
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (ei = 0; ei < 32; ei = ei + 1) begin
				tx_code[ei] <= `RST_REG8;
				rx_code[ei] <= `RST_REG8;
			end
		end else if (code_write) begin
			for (ei = 0; ei < 32; ei = ei + 1) begin
				// RULE_14: commit on code write
				// RULE_01: flags pick the target
				if (global_tx_fill_flag)
					tx_code[ei] <= pwdata[7:0];
				// RULE_02: global rx fill
				if (global_rx_fill_flag)
					rx_code[ei] <= pwdata[7:0];
				// RULE_15: both sides updated
				if (!global_tx_fill_flag && !global_rx_fill_flag && single_hit[ei]) begin
					tx_code[ei] <= pwdata[7:0];
					rx_code[ei] <= pwdata[7:0];
				end
			end
		end
	end

	// ======================================================
	// read data, captured in setup phase
	always @* begin
		next_rdata = 8'h00;
		if (reg_index == {2'h0, `IDX_LINE_CONTROL})
			next_rdata = {line_standard_select, 7'h00};
		else if (reg_index == {2'h0, `IDX_TERMINATION_CONTROL})
			next_rdata = {4'h0, termination_control};
		else if (reg_index == {2'h0, `IDX_IDLE_ARRAY_POINTER})
			next_rdata = idle_array_pointer;
		// RULE_03: array read assumes flags clear
		else if (reg_index == {2'h0, `IDX_IDLE_CODE_VALUE})
			next_rdata = pointer_ok ? tx_code[pointer_idx] : idle_code_value;
		else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH1_8})
			next_rdata = tx_enable[7:0];
		else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH9_16})
			next_rdata = tx_enable[15:8];
		else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH17_24})
			next_rdata = tx_enable[23:16];
		else if (reg_index == {2'h0, `IDX_TX_IDLE_ENABLE_CH25_32})
			next_rdata = tx_enable[31:24];
		else if (reg_index == {2'h0, `IDX_RX_IDLE_ENABLE_CH1_8})
			next_rdata = rx_enable[7:0];
		else if (reg_index == {2'h0, `IDX_RX_IDLE_ENABLE_CH9_16})
			next_rdata = rx_enable[15:8];
		else if (reg_index == {2'h0, `IDX_RX_IDLE_ENABLE_CH17_24})
			next_rdata = rx_enable[23:16];
	end

	// read data register
	// loaded in setup so it stands through the access phase
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			prdata <= 32'h00000000;
		else if (setup)
			prdata <= (mapped && !pwrite) ? {24'h000000, next_rdata} : 32'h00000000;
	end

	// ======================================================
	// timeslot substitution
	assign tx_idx         = tx_in_channel[4:0] - 5'h01;
	assign rx_idx         = rx_in_channel[4:0] - 5'h01;
	// no rx enables above channel 24, those bits stay zero
	assign rx_enable_full = {8'h00, rx_enable};
	// out of range channels pass unchanged
	// RULE_08: tx enabled slot replaced
	assign tx_hit      = chan_ok(tx_in_channel, line_standard_select) && tx_enable[tx_idx];
	assign tx_sub_data = tx_hit ? tx_code[tx_idx] : tx_in_data;
	// RULE_09: rx enabled slot replaced
	assign rx_hit      = chan_ok(rx_in_channel, line_standard_select) && rx_enable_full[rx_idx];
	assign rx_sub_data = rx_hit ? rx_code[rx_idx] : rx_in_data;

	// transmit buffering
	stream_fifo #(
		.WIDTH (14),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_tx_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (tx_in_valid),
		.in_ready  (tx_in_ready),
		.in_data   ({tx_in_channel, tx_sub_data}),
		.out_valid (tx_out_valid),
		.out_ready (tx_out_ready),
		.out_data  ({tx_out_channel, tx_out_data})
	);

	// receive buffering
	stream_fifo #(
		.WIDTH (14),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_rx_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   ({rx_in_channel, rx_sub_data}),
		.out_valid (rx_out_valid),
		.out_ready (rx_out_ready),
		.out_data  ({rx_out_channel, rx_out_data})
	);
endmodule // per_channel_idle_code_insert

// [test/idle_code_host.sv]
`timescale 1ns/1ps
// ==========================================================
// apb master standing in for the host processor
module idle_code_host (
	// clock
	input  wire		clk,
	// apb request
	output reg		psel,
	output reg		penable,
	output reg		pwrite,
	output reg  [11:0]	paddr,
	output reg  [31:0]	pwdata,
	// apb answer
	input  wire		pready,
	input  wire		pslverr,
	input  wire [31:0]	prdata
);
	reg [31:0]	rdata;
	reg		rerr;
	// idle bus from time zero
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
	end
	// one transfer, held until pready is seen high
	task xfer(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1;
			do @(posedge clk); while (pready !== 1'b1);
			rdata = prdata;
			rerr = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge clk);
		end
	endtask
endmodule // idle_code_host

// [test/per_channel_idle_code_insert_monitor.sv]
`timescale 1ns/1ps
// ==========================================================
// port checker
module per_channel_idle_code_insert_monitor (
	// clock, reset, apb
	input wire		clk, rst_b, psel, penable, pwrite, pslverr,
	input wire [11:0]	paddr,
	input wire [31:0]	pwdata, prdata,
	// streams
	input wire		tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready,
	input wire		rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready,
	input wire [5:0]	tx_in_channel, tx_out_channel, rx_in_channel, rx_out_channel,
	input wire [7:0]	tx_out_data, rx_out_data,
	// line configuration
	input wire		line_standard_select,
	input wire [2:0]	tx_termination_onehot, rx_termination_onehot
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// write commit strobe
	wire wr = psel & penable & pwrite;
	// one-hot view of a termination field
	function [2:0] oh(input [1:0] s);
		oh = (s == 2'h0) ? 3'h0 : 3'h1 << (s - 2'h1);
	endfunction
	AST_TX_TERM: assert property (
		wr && paddr == 12'h1ec |-> ##2 tx_termination_onehot == oh($past(pwdata[3:2], 2)))
		else $error("tx termination decode wrong");
	AST_RX_TERM: assert property (
		wr && paddr == 12'h1ec |-> ##2 rx_termination_onehot == oh($past(pwdata[1:0], 2)))
		else $error("rx termination decode wrong");
	AST_LINE_STD: assert property (
		wr && paddr == 12'h1e4 |=> line_standard_select == $past(pwdata[7]))
		else $error("line standard bit not taken");
	AST_BAD_ADDR: assert property (
		psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	AST_RD_WIDTH: assert property (
		psel && penable && !pwrite && !pslverr |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_TX_HOLD: assert property (
		tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable({tx_out_data, tx_out_channel}))
		else $error("tx head moved while stalled");
	AST_RX_HOLD: assert property (
		rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable({rx_out_data, rx_out_channel}))
		else $error("rx head moved while stalled");
	AST_TX_FIRST: assert property (
		tx_in_valid && tx_in_ready && !tx_out_valid |=>
		tx_out_valid && tx_out_channel == $past(tx_in_channel))
		else $error("tx byte not out next cycle");
	AST_RX_FIRST: assert property (
		rx_in_valid && rx_in_ready && !rx_out_valid |=>
		rx_out_valid && rx_out_channel == $past(rx_in_channel))
		else $error("rx byte not out next cycle");
	// main scenarios
	cover property (wr && paddr == 12'h1fc);
	cover property (tx_out_valid && tx_out_ready);
	cover property (psel && penable && pslverr);
endmodule // per_channel_idle_code_insert_monitor

// [test/per_channel_idle_code_insert_tb.sv]
`timescale 1ns/1ps
`include "idle_code_map.vh"
// ==========================================================
// bench top
module per_channel_idle_code_insert_tb;
	reg		clk, rst_b, stall, drain, e1, tx_in_valid, rx_in_valid, tx_out_ready, rx_out_ready;
	reg [7:0]	tx_in_data, rx_in_data, c;
	reg [5:0]	tx_in_channel, rx_in_channel;
	wire		psel, penable, pwrite, pready, pslverr, line_standard_select;
	wire		tx_in_ready, rx_in_ready, tx_out_valid, rx_out_valid;
	wire [11:0]	paddr;
	wire [31:0]	pwdata, prdata;
	wire [7:0]	tx_out_data, rx_out_data;
	wire [5:0]	tx_out_channel, rx_out_channel;
	wire [2:0]	tx_termination_onehot, rx_termination_onehot;
	integer		errors, n_compared, cyc, i, s;
	reg [7:0]	code [2][1:32];
	reg [32:1]	en [2];
	reg [13:0]	qt [$], qr [$];
	per_channel_idle_code_insert dut_u (.*);
	idle_code_host host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
	// count one comparison
	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			n_compared++;
			if (got !== exp) begin
				errors++;
				$display("BAD %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task wr(input [9:0] a, input [7:0] d);
		host_u.xfer(1, {a, 2'b00}, {24'h0, d});
	endtask
	task rd_chk(input string what, input [9:0] a, input [7:0] e);
		begin
			host_u.xfer(0, {a, 2'b00}, 0);
			chk(what, {24'h0, e}, host_u.rdata);
		end
	endtask
	// pointer then code, model the entries hit
	task fill(input [7:0] p);
		begin
			wr(`IDX_IDLE_ARRAY_POINTER, p);
			c = $urandom;
			wr(`IDX_IDLE_CODE_VALUE, c);
			for (i = 1; i <= 32; i++) begin
				if (p[7] || (!p[6] && p[5:0] == i)) code[1][i] = c;
				if (p[6] || (!p[7] && p[5:0] == i)) code[0][i] = c;
			end
		end
	endtask
	// expected byte and channel leaving a stream
	function [13:0] ex(input s, input [5:0] ch, input [7:0] d);
		ex = {ch, (ch >= 1 && ch <= ((s || !e1) ? 24 : 32) && en[s][ch]) ? code[s][ch] : d};
	endfunction
	// one byte into both streams
	task push(input [5:0] ch);
		begin
			tx_in_valid <= 1;
			rx_in_valid <= 1;
			tx_in_channel <= ch;
			rx_in_channel <= ch;
			tx_in_data <= $urandom;
			rx_in_data <= $urandom;
			do @(posedge clk); while (!(tx_in_ready === 1'b1 && rx_in_ready === 1'b1));
			qt.push_back(ex(0, ch, tx_in_data));
			qr.push_back(ex(1, ch, rx_in_data));
		end
	endtask
	task report_and_stop;
		begin
			$display("compared %0d mismatches %0d", n_compared, errors);
			if (errors == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// sink, both sides stall together; output scoreboard
	always @(posedge clk) begin
		drain = !stall && ($urandom % 4 != 0);
		tx_out_ready <= drain;
		rx_out_ready <= drain;
		if (tx_out_valid && tx_out_ready) chk("tx out", qt.pop_front(), {tx_out_channel, tx_out_data});
		if (rx_out_valid && rx_out_ready) chk("rx out", qr.pop_front(), {rx_out_channel, rx_out_data});
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop;
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		{rst_b, tx_in_valid, rx_in_valid, tx_out_ready, rx_out_ready} = 0;
		{tx_in_data, rx_in_data, tx_in_channel, rx_in_channel} = 0;
		{errors, n_compared, cyc} = 0;
		stall = 1;
		s = $urandom(15);
		repeat (4) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		for (i = 0; i < 11; i++) rd_chk("reset value", (i == 0) ? 'h79 : (i == 1) ? 'h7b : 'h7c + i, 0);
		host_u.xfer(0, 12'h220, 0);
		chk("unmapped refused", 1, host_u.rerr);
		host_u.xfer(1, 12'h1fd, 32'h000000a5);
		chk("unaligned refused", 1, host_u.rerr);
		rd_chk("unaligned ignored", `IDX_IDLE_CODE_VALUE, 0);
		for (s = 0; s < 7; s++) begin
			c = $urandom;
			wr(`IDX_TX_IDLE_ENABLE_CH1_8 + s, c);
			rd_chk("enable readback", `IDX_TX_IDLE_ENABLE_CH1_8 + s, c);
			en[s > 3][(s % 4) * 8 + 1 +: 8] = c;
		end
		$display("test registers done");
		for (s = 0; s < 4; s++) begin
			wr(`IDX_TERMINATION_CONTROL, {s[1:0], 2'(3 - s)});
			repeat (2) @(posedge clk);
			chk("tx termination", (s == 0) ? 0 : 1 << (s - 1), tx_termination_onehot);
			chk("rx termination", (s == 3) ? 0 : 1 << (2 - s), rx_termination_onehot);
		end
		for (s = 0; s < 2; s++) begin
			wr(`IDX_LINE_CONTROL, {s[0], 7'h0});
			e1 = s[0];
			chk("line standard", s, line_standard_select);
		end
		$display("test line config done");
		fill(8'hc1);
		fill(8'h81);
		fill(8'h41);
		for (s = 0; s < 6; s++) begin
			fill(8'h01 + $urandom % 32);
			rd_chk("code readback", `IDX_IDLE_CODE_VALUE, c);
		end
		$display("test code fill done");
		stall = 0;
		for (s = 0; s < 80; s++) push($urandom % 34);
		tx_in_valid <= 0;
		rx_in_valid <= 0;
		while (qt.size() || qr.size()) @(posedge clk);
		stall = 1;
		repeat (2) @(posedge clk);
		for (s = 0; s < 16; s++) push(s + 1);
		tx_in_valid <= 0;
		rx_in_valid <= 0;
		@(negedge clk);
		chk("full refuses", 0, {rx_in_ready, tx_in_ready});
		stall = 0;
		while (qt.size() || qr.size()) @(posedge clk);
		$display("test streams done");
		wr(`IDX_LINE_CONTROL, 8'h00);
		e1 = 0;
		for (s = 0; s < 28; s++) push(20 + s % 14);
		tx_in_valid <= 0;
		rx_in_valid <= 0;
		while (qt.size() || qr.size()) @(posedge clk);
		$display("test t1 channel count done");
		report_and_stop;
	end
endmodule // per_channel_idle_code_insert_tb
bind per_channel_idle_code_insert per_channel_idle_code_insert_monitor mon_u (.*);
